// ---- pmc_pkg.sv ----
// Behaviour
// - wake flag sets on any wake event, except during a bus reset with enable off
// - writing one clears flag, releases wake
// - data scale field always reads zero
// - data select field always reads zero
// - wake pin driven only while enabled
// - wake enable survives bus reset
// - flag kept through bus reset if enabled
// - reserved control bits read zero
// - power state readable and writable, encoded
// - internal reset leaves this register untouched
// - d3hot to d0 resets other registers
// - bus power clock control reads one
// - disabled control leaves secondary bus alone
// - d3hot action bit picks clock or power
// - power data byte always reads zero
`default_nettype none
package pmc_pkg;

	// ************************************************************
	// configuration space placement
	// ************************************************************
	localparam logic [7:0] PMC_OFF_CSR  = 8'ha4; // control/status, lanes 0-1
	localparam logic [7:0] PMC_OFF_BSE  = 8'ha6; // bridge extensions, lane 2
	localparam logic [7:0] PMC_OFF_DATA = 8'ha7; // data byte, lane 3

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int PMC_FLAG_BIT = 15; // wake_event_flag
	localparam int PMC_EN_BIT   = 8;  // wake_assert_enable
	localparam int PMC_PS_LSB   = 0;  // power_state_field
	localparam int PMC_BPCC_BIT = 7;  // secondary_bus_power_clock_ctrl_en
	localparam int PMC_B2B3_BIT = 6;  // d3hot_secondary_action

	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [15:0] PMC_CSR_RST  = 16'h0000;
	localparam logic [7:0]  PMC_BSE_RST  = 8'hc0;
	localparam logic [7:0]  PMC_DATA_RST = 8'h00;
	localparam logic [2:0]  PMC_FRST_CYCLES = 3'h4; // internal reset width

	// power state encodings
	typedef enum logic [1:0] {
		PMC_D0    = 2'h0,
		PMC_D1    = 2'h1,
		PMC_D2    = 2'h2,
		PMC_D3HOT = 2'h3
	} pmc_pstate_t;

	// internal reset sequencer, one-hot
	typedef enum logic [1:0] {
		PMC_SQ_RUN  = 2'h1,
		PMC_SQ_FRST = 2'h2
	} pmc_seq_t;

endpackage
`default_nettype wire

// ---- pmc_wake_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries wake control between the register bank and the wake keeper
interface pmc_wake_if;
	logic wake_set;   // function would assert wake this cycle
	logic flag_clr;   // software wrote one to the flag
	logic en_wr;      // software wrote the enable lane
	logic en_wdata;   // value written to the enable
	logic bus_rst;    // pci bus reset asserted (active high here)
	logic flag;       // wake_event_flag state
	logic enable;     // wake_assert_enable state
	logic pme_drive;  // wake pin driven low

	modport csr (output wake_set, flag_clr, en_wr, en_wdata, bus_rst,
		input flag, enable, pme_drive);
	modport wake (input wake_set, flag_clr, en_wr, en_wdata, bus_rst,
		output flag, enable, pme_drive);
endinterface
`default_nettype wire

// ---- pmc_wake.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_wake
	import pmc_pkg::*;
(
	input  wire logic clk,   // 100 MHz
	input  wire logic rst_b, // global reset, async, active low
	pmc_wake_if.wake  wif    // wake control
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ************************************************************
	// wake enable: only the global reset or a software write clears it
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wif.enable <= PMC_CSR_RST[PMC_EN_BIT];
		end else if (wif.en_wr) begin
			wif.enable <= wif.en_wdata;
		end
	end

	// ************************************************************
	// wake flag: event wins over a same-cycle write-one clear
	// ************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wif.flag <= PMC_CSR_RST[PMC_FLAG_BIT];
		end else if (wif.bus_rst && !wif.enable) begin
			wif.flag <= 1'b0;
		end else if (wif.wake_set) begin
			wif.flag <= 1'b1;
		end else if (wif.flag_clr) begin
			wif.flag <= 1'b0;
		end
	end

	// open-drain drive follows the flag, gated by the enable
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wif.pme_drive <= 1'b0;
		end else begin
			wif.pme_drive <= wif.flag && wif.enable;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	property p_set_wins;
		wif.wake_set && !(wif.bus_rst && !wif.enable) |=> wif.flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("wake event lost");

	property p_clear_one;
		wif.flag_clr && !wif.wake_set |=> !wif.flag ##1 !wif.pme_drive;
	endproperty
	a_clear_one: assert property (p_clear_one) else $error("flag clear failed");

	property p_gate;
		!wif.enable |=> !wif.pme_drive;
	endproperty
	a_gate: assert property (p_gate) else $error("wake driven while disabled");

	property p_en_keep;
		wif.bus_rst && !wif.en_wr |=> $stable(wif.enable);
	endproperty
	a_en_keep: assert property (p_en_keep) else $error("enable lost on bus reset");

	property p_ctx;
		wif.bus_rst && wif.enable && wif.flag && !wif.flag_clr |=> wif.flag;
	endproperty
	a_ctx: assert property (p_ctx) else $error("wake context lost");

	c_pme: cover property (wif.flag && wif.enable ##1 wif.pme_drive);
endmodule
`default_nettype wire

// ---- pmc_csr.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_csr
	import pmc_pkg::*;
(
	input  wire logic        clk,                  // 100 MHz
	input  wire logic        rst_b,                // global reset pin, async
	input  wire logic        pci_bus_reset_pin_b,  // pci bus reset, sync level
	input  wire logic        cfg_wr,               // config write strobe
	input  wire logic        cfg_rd,               // config read strobe
	input  wire logic [7:0]  cfg_addr,             // config byte address
	input  wire logic [3:0]  cfg_be,               // byte enables
	input  wire logic [31:0] cfg_wdata,            // write data
	input  wire logic        wake_event,           // function would assert wake
	output logic      [31:0] cfg_rdata,            // read data
	output logic             cfg_rvalid,           // read data valid pulse
	output logic             pme_o,                // wake pin level when driven
	output logic             pme_oe,               // wake pin drive enable
	output logic             func_reset,           // internal reset to other regs
	output logic             sec_clk_stop,         // secondary bus clock stopped
	output logic             sec_power_off,        // secondary bus power removed
	output logic [1:0]       power_state           // present power state
);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ************************************************************
	// declarations
	// ************************************************************
	pmc_wake_if  wif ();

	pmc_pstate_t ps_q;        // power_state_field
	pmc_pstate_t ps_d;
	pmc_seq_t    seq_q;       // internal reset sequencer
	pmc_seq_t    seq_d;
	logic [2:0]  frst_cnt_q;  // internal reset cycles left
	logic [2:0]  frst_cnt_d;
	logic        hit;         // access lands on the power dword
	logic        wr_lane0;    // write touches power state byte
	logic        wr_lane1;    // write touches flag / enable byte
	logic        bus_rst;     // pci bus reset asserted
	logic        d3_to_d0;    // write moves d3hot to d0
	logic [7:0]  bse;         // bridge extension byte
	logic [15:0] csr_rd;      // control/status read image
	logic [31:0] rdata_d;

	// ************************************************************
	// address decode
	// ************************************************************
	// the three registers share one dword; lanes pick the byte
	assign hit      = (cfg_addr[7:2] == PMC_OFF_CSR[7:2]);
	assign wr_lane0 = cfg_wr && hit && cfg_be[PMC_OFF_CSR[1:0]];
	assign wr_lane1 = cfg_wr && hit && cfg_be[PMC_OFF_CSR[1:0] + 2'h1];
	assign bus_rst  = !pci_bus_reset_pin_b;

	// lanes 2 and 3 hold fixed values, writes there fall away
	assign bse = PMC_BSE_RST;

	// ************************************************************
	// wake keeper hookup
	// ************************************************************
	// flag clear and enable write ride byte lane 1
	assign wif.wake_set = wake_event;
	assign wif.flag_clr = wr_lane1 && cfg_wdata[PMC_FLAG_BIT];
	assign wif.en_wr    = wr_lane1;
	assign wif.en_wdata = cfg_wdata[PMC_EN_BIT];
	assign wif.bus_rst  = bus_rst;

	pmc_wake u_wake (
		.clk   (clk),
		.rst_b (rst_b),
		.wif   (wif)
	);

	// pin is open-drain: level is always low, only the enable moves
	assign pme_oe = wif.pme_drive;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pme_o <= 1'b0;
		end else begin
			pme_o <= 1'b0;
		end
	end

	// ************************************************************
	// power state field
	// ************************************************************
	// any encoding is accepted; bus reset returns the function to d0
	always_comb begin
		ps_d = ps_q;
		if (bus_rst) begin
			ps_d = PMC_D0;
		end else if (wr_lane0) begin
			ps_d = pmc_pstate_t'(cfg_wdata[PMC_PS_LSB +: 2]);
		end
	end

	// internal reset never touches this register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ps_q <= pmc_pstate_t'(PMC_CSR_RST[PMC_PS_LSB +: 2]);
		end else begin
			ps_q <= ps_d;
		end
	end

	// a registered copy for the rest of the function
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			power_state <= PMC_CSR_RST[PMC_PS_LSB +: 2];
		end else begin
			power_state <= ps_d;
		end
	end

	// ************************************************************
	// d3hot to d0 internal reset sequencer
	// ************************************************************
	assign d3_to_d0 = wr_lane0 && !bus_rst && (ps_q == PMC_D3HOT)
		&& (cfg_wdata[PMC_PS_LSB +: 2] == PMC_D0);

	// held several cycles so slow register groups all see it
	always_comb begin
		seq_d      = seq_q;
		frst_cnt_d = frst_cnt_q;
		case (seq_q)
			PMC_SQ_RUN: begin
				if (d3_to_d0) begin
					seq_d      = PMC_SQ_FRST;
					frst_cnt_d = PMC_FRST_CYCLES - 3'h1;
				end
			end
			PMC_SQ_FRST: begin
				if (frst_cnt_q == 3'h0) begin
					seq_d = PMC_SQ_RUN;
				end else begin
					frst_cnt_d = frst_cnt_q - 3'h1;
				end
			end
			default: begin
				seq_d      = PMC_SQ_RUN;
				frst_cnt_d = 3'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_q      <= PMC_SQ_RUN;
			frst_cnt_q <= 3'h0;
		end else begin
			seq_q      <= seq_d;
			frst_cnt_q <= frst_cnt_d;
		end
	end

	// wake context and global-only bits live outside this reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			func_reset <= 1'b0;
		end else begin
			func_reset <= (seq_d == PMC_SQ_FRST);
		end
	end

	// ************************************************************
	// secondary bus policy
	// ************************************************************
	// when control is disabled the power state has no say here
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_clk_stop  <= 1'b0;
			sec_power_off <= 1'b0;
		end else if (bse[PMC_BPCC_BIT] && ps_q == PMC_D3HOT) begin
			sec_clk_stop  <= bse[PMC_B2B3_BIT];
			sec_power_off <= !bse[PMC_B2B3_BIT];
		end else begin
			sec_clk_stop  <= 1'b0;
			sec_power_off <= 1'b0;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	// scale, select and reserved bits are tied to zero
	always_comb begin
		csr_rd                        = 16'h0000;
		csr_rd[PMC_FLAG_BIT]          = wif.flag;
		csr_rd[PMC_EN_BIT]            = wif.enable;
		csr_rd[PMC_PS_LSB +: 2]       = ps_q;
		rdata_d                       = 32'h0000_0000;
		if (hit) begin
			rdata_d = {PMC_DATA_RST, bse, csr_rd};
		end
	end

	// one-cycle read latency, unmapped dwords read zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_rdata  <= 32'h0000_0000;
			cfg_rvalid <= 1'b0;
		end else begin
			cfg_rvalid <= cfg_rd;
			if (cfg_rd) begin
				cfg_rdata <= rdata_d;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	// read image: fixed upper bytes and the always-zero fields
	property p_fixed_bytes;
		cfg_rd && hit |=> cfg_rvalid && cfg_rdata[23:16] == PMC_BSE_RST;
	endproperty
	a_fixed_bytes: assert property (p_fixed_bytes) else $error("fixed bytes wrong");

	property p_data_byte;
		cfg_rd && hit |=> cfg_rdata[31:24] == PMC_DATA_RST;
	endproperty
	a_data_byte: assert property (p_data_byte) else $error("data byte not zero");

	// bit 8 is the live enable, so the zero ranges skip it
	property p_zero_fields;
		cfg_rvalid |-> cfg_rdata[14:13] == 2'h0;
	endproperty
	a_zero_fields: assert property (p_zero_fields) else $error("zero field set");

	property p_select_zero;
		cfg_rvalid |-> cfg_rdata[12:9] == 4'h0;
	endproperty
	a_select_zero: assert property (p_select_zero) else $error("select field set");

	property p_rsvd_zero;
		cfg_rvalid |-> cfg_rdata[7:2] == 6'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

	// read image: live fields of the control/status word
	property p_ps_image;
		cfg_rd && hit |=> cfg_rdata[PMC_PS_LSB +: 2] == $past(ps_q);
	endproperty
	a_ps_image: assert property (p_ps_image) else $error("power state misread");

	property p_wake_image;
		cfg_rd && hit |=> cfg_rdata[PMC_FLAG_BIT] == $past(wif.flag)
			&& cfg_rdata[PMC_EN_BIT] == $past(wif.enable);
	endproperty
	a_wake_image: assert property (p_wake_image) else $error("flag or enable misread");

	// read strobe timing, unmapped space and power state write
	property p_rvalid_pulse;
		1'b1 |=> cfg_rvalid == $past(cfg_rd);
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid timing");

	property p_unmapped;
		cfg_rd && !hit |=> cfg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_ps_write;
		wr_lane0 && pci_bus_reset_pin_b |=> ps_q == $past(cfg_wdata[1:0]);
	endproperty
	a_ps_write: assert property (p_ps_write) else $error("power state not written");

	// bus reset parks the function in d0
	property p_bus_rst_ps;
		bus_rst |=> ps_q == PMC_D0;
	endproperty
	a_bus_rst_ps: assert property (p_bus_rst_ps) else $error("bus reset left state");

	property p_state_copy;
		1'b1 |-> power_state == ps_q;
	endproperty
	a_state_copy: assert property (p_state_copy) else $error("state copy differs");

	property p_frst_len;
		d3_to_d0 && seq_q == PMC_SQ_RUN |=> func_reset [*4] ##1 !func_reset;
	endproperty
	a_frst_len: assert property (p_frst_len) else $error("internal reset width");

	property p_frst_cause;
		$rose(func_reset) |-> $past(d3_to_d0);
	endproperty
	a_frst_cause: assert property (p_frst_cause) else $error("stray internal reset");

	property p_frst_seq;
		1'b1 |-> func_reset == (seq_q == PMC_SQ_FRST);
	endproperty
	a_frst_seq: assert property (p_frst_seq) else $error("reset out of sequence");

	property p_csr_keep;
		func_reset && !wr_lane0 && pci_bus_reset_pin_b |=> $stable(ps_q);
	endproperty
	a_csr_keep: assert property (p_csr_keep) else $error("csr hit by internal reset");

	property p_d3_clk;
		ps_q == PMC_D3HOT |=> sec_clk_stop && !sec_power_off;
	endproperty
	a_d3_clk: assert property (p_d3_clk) else $error("d3hot action wrong");

	property p_not_d3;
		ps_q != PMC_D3HOT |=> !sec_clk_stop && !sec_power_off;
	endproperty
	a_not_d3: assert property (p_not_d3) else $error("secondary bus touched");

	property p_ro_write;
		cfg_wr && hit && cfg_be[3:2] != 2'h0 |=> $stable(ps_q) || $past(wr_lane0 || bus_rst);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write leaked");

	// clock stop and power removal never both at once
	property p_sec_excl;
		1'b1 |-> !(sec_clk_stop && sec_power_off);
	endproperty
	a_sec_excl: assert property (p_sec_excl) else $error("secondary bus both off");

	// ************************************************************
	// wake pin and wake control checks
	// ************************************************************
	property p_pme_level;
		pme_oe |-> !pme_o;
	endproperty
	a_pme_level: assert property (p_pme_level) else $error("wake pin driven high");

	property p_pme_follow;
		1'b1 |=> pme_oe == $past(wif.flag && wif.enable);
	endproperty
	a_pme_follow: assert property (p_pme_follow) else $error("wake drive mismatch");

	property p_en_write;
		wr_lane1 |=> wif.enable == $past(cfg_wdata[PMC_EN_BIT]);
	endproperty
	a_en_write: assert property (p_en_write) else $error("enable not written");

	// a zero written to the flag must leave it set
	property p_flag_keep0;
		wr_lane1 && !cfg_wdata[PMC_FLAG_BIT] && wif.flag && !bus_rst |=> wif.flag;
	endproperty
	a_flag_keep0: assert property (p_flag_keep0) else $error("flag lost on zero write");

	c_d3_d0:   cover property (d3_to_d0 ##1 func_reset);
	c_flag:    cover property (wake_event ##1 wif.flag ##[1:4] wif.flag_clr);
	c_bus_rst: cover property (wif.enable && bus_rst ##1 wif.enable);
	c_read:    cover property (cfg_rd && hit ##1 cfg_rvalid);

endmodule
`default_nettype wire

// ---- pmc_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// config host model
// ****
module pmc_host (
	input  wire logic        clk,        // 100 MHz
	input  wire logic [31:0] cfg_rdata,  // read data
	input  wire logic        cfg_rvalid, // read valid pulse
	output logic             cfg_wr,     // write strobe
	output logic             cfg_rd,     // read strobe
	output logic      [7:0]  cfg_addr,   // byte address
	output logic      [3:0]  cfg_be,     // byte enables
	output logic      [31:0] cfg_wdata   // write data
);
	// idle bus at time zero
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end

	// released lines flip so stale values are never trusted
	task automatic drop();
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		cfg_addr <= ~cfg_addr;
		cfg_be <= ~cfg_be;
		cfg_wdata <= ~cfg_wdata;
	endtask

	// one write, held for exactly one taking edge
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_be <= be;
		cfg_wdata <= d;
		@(posedge clk);
		drop();
	endtask

	// one read, answer awaited for a bounded number of edges
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output bit ok);
		ok = 1'b0;
		d = 32'h0;
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		cfg_be <= 4'hf;
		@(posedge clk);
		drop();
		for (int i = 0; i < 4 && !ok; i++) begin
			@(posedge clk);
			if (cfg_rvalid === 1'b1) begin
				ok = 1'b1;
				d = cfg_rdata;
			end
		end
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
	import pmc_pkg::*;
;
	logic        clk, rst_b, bus_rst_b, wake_event;
	logic        cfg_wr, cfg_rd, cfg_rvalid, pme_o, pme_oe;
	logic        func_reset, sec_clk_stop, sec_power_off;
	logic [7:0]  cfg_addr;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, rv;
	logic [1:0]  power_state;
	int          err_count, comparisons;

	// ****
	// partner and design
	// ****
	pmc_host i_host (.clk(clk), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata));
	pmc_csr i_dut (.clk(clk), .rst_b(rst_b), .pci_bus_reset_pin_b(bus_rst_b),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .wake_event(wake_event), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid), .pme_o(pme_o), .pme_oe(pme_oe),
		.func_reset(func_reset), .sec_clk_stop(sec_clk_stop),
		.sec_power_off(sec_power_off), .power_state(power_state));

	// ****
	// helpers
	// ****
	// whole dword: data byte, extension byte, control/status
	function automatic logic [31:0] csr(input logic f, input logic e, input logic [1:0] p);
		return {PMC_DATA_RST, PMC_BSE_RST, f, 6'h00, e, 6'h00, p};
	endfunction

	task automatic give_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	// a lost answer ends the run rather than hanging it
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bit ok;
		i_host.rd(a, rv, ok);
		if (!ok) begin
			err_count++;
			give_verdict();
		end else begin
			chk("read data", e, rv);
		end
	endtask

	// two edges of margin: flag lands first, pin drive one cycle later
	task automatic pulse_wake();
		@(posedge clk) wake_event <= 1'b1;
		@(posedge clk) wake_event <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic bus_reset();
		@(posedge clk) bus_rst_b <= 1'b0;
		@(posedge clk) bus_rst_b <= 1'b1;
		@(posedge clk);
	endtask

	// ****
	// scenarios
	// ****
	task automatic sc_reset_values();
		rdc(PMC_OFF_CSR, csr(0, 0, PMC_D0));
		rdc(8'ha0, 32'h0);
		chk("pme drive", 32'h0, {31'h0, pme_oe});
	endtask

	task automatic sc_read_only();
		i_host.wr(PMC_OFF_CSR, 4'hc, 32'hffffffff);
		i_host.wr(PMC_OFF_CSR, 4'h3, 32'h7efc);
		rdc(PMC_OFF_CSR, csr(0, 0, PMC_D0));
	endtask

	task automatic sc_power_states();
		int n;
		n = 0;
		i_host.wr(PMC_OFF_CSR, 4'h2, 32'h0100);
		for (int s = 1; s < 4; s++) begin
			i_host.wr(PMC_OFF_CSR, 4'h1, 32'(s));
			rdc(PMC_OFF_CSR, csr(0, 1, 2'(s)));
			chk("power state", 32'(s), {30'h0, power_state});
		end
		chk("clock stop", 32'h1, {31'h0, sec_clk_stop});
		chk("power off", 32'h0, {31'h0, sec_power_off});
		i_host.wr(PMC_OFF_CSR, 4'h1, 32'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			n += (func_reset === 1'b1);
		end
		chk("reset width", 32'(PMC_FRST_CYCLES), 32'(n));
		rdc(PMC_OFF_CSR, csr(0, 1, PMC_D0));
		chk("clock stop", 32'h0, {31'h0, sec_clk_stop});
	endtask

	task automatic sc_wake_enabled();
		pulse_wake();
		chk("pme drive", 32'h1, {31'h0, pme_oe});
		chk("pme level", 32'h0, {31'h0, pme_o});
		rdc(PMC_OFF_CSR, csr(1, 1, PMC_D0));
		i_host.wr(PMC_OFF_CSR, 4'h2, 32'h0100);
		rdc(PMC_OFF_CSR, csr(1, 1, PMC_D0));
		bus_reset();
		rdc(PMC_OFF_CSR, csr(1, 1, PMC_D0));
		i_host.wr(PMC_OFF_CSR, 4'h2, 32'h8100);
		repeat (2) @(posedge clk);
		chk("pme drive", 32'h0, {31'h0, pme_oe});
		rdc(PMC_OFF_CSR, csr(0, 1, PMC_D0));
	endtask

	task automatic sc_wake_disabled();
		i_host.wr(PMC_OFF_CSR, 4'h2, 32'h0);
		pulse_wake();
		chk("pme drive", 32'h0, {31'h0, pme_oe});
		rdc(PMC_OFF_CSR, csr(1, 0, PMC_D0));
		bus_reset();
		rdc(PMC_OFF_CSR, csr(0, 0, PMC_D0));
	endtask

	// only the global reset or a software write may drop enable and an enabled flag
	task automatic sc_global_reset();
		i_host.wr(PMC_OFF_CSR, 4'h2, 32'h0100);
		pulse_wake();
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdc(PMC_OFF_CSR, csr(0, 0, PMC_D0));
	endtask

	// ****
	// clock and main sequence
	// ****
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		rst_b = 1'b0;
		bus_rst_b = 1'b1;
		wake_event = 1'b0;
		err_count = 0;
		comparisons = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		sc_reset_values();
		sc_read_only();
		sc_power_states();
		sc_wake_enabled();
		sc_wake_disabled();
		sc_global_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
